// file: hdl/csm_consts.vh
// constants for the current sense output mux block
`ifndef CSM_CONSTS_VH
`define CSM_CONSTS_VH

// ==========================================================
// register indices (byte address is four times the index)
`define CSM_IDX_OUT_ONE_CFG   10'h1AA
`define CSM_IDX_OUT_TWO_CFG   10'h1AB
`define CSM_IDX_STATUS        10'h1AC

// ==========================================================
// output config field positions
`define CSM_SRC_LSB           0
`define CSM_SRC_MSB           2
`define CSM_EN_BIT            3
`define CSM_GAIN_LSB          4
`define CSM_GAIN_MSB          5
`define CSM_CFG_MASK          16'h003F

// ==========================================================
// reset values
`define CSM_CFG_RESET         16'h0000

// ==========================================================
// select codes
`define CSM_SEL_CUR_A         3'h0
`define CSM_SEL_CUR_B         3'h1
`define CSM_SEL_REF           3'h5

// ==========================================================
// gain codes
`define CSM_GAIN_1V33         2'h0
`define CSM_GAIN_2V0          2'h1
`define CSM_GAIN_3V0          2'h2
`define CSM_GAIN_5V33         2'h3

// ==========================================================
// status bit positions
`define CSM_ST_HIGH_BIT       0
`define CSM_ST_LOW_BIT        1
`define CSM_ST_NEG_BIT        2
`define CSM_ST_RES_ONE_BIT    3
`define CSM_ST_RES_TWO_BIT    4

`endif

// file: hdl/csm_pin_slice.v
// one output pin: select decode, gain, enable and bias control
`timescale 1ns/100ps
`include "csm_consts.vh"

module csm_pin_slice
(
  // clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // configuration
  input  wire [2:0] src_sel,
  input  wire       pin_en,
  input  wire [1:0] gain_code,
  // analogue switch controls
  output reg        route_cur_a,
  output reg        route_cur_b,
  output reg        route_ref,
  output reg        drive_oe,
  output reg  [1:0] output_gain_select,
  output reg        bias_remove,
  output reg        sel_reserved
);

  // ==========================================================
  // decode
  reg       cur_a_nxt;
  reg       cur_b_nxt;
  reg       ref_nxt;
  reg       res_nxt;

  always @*
  begin
    cur_a_nxt = 1'b0;
    cur_b_nxt = 1'b0;
    ref_nxt   = 1'b0;
    res_nxt   = 1'b0;
    case (src_sel)
      `CSM_SEL_CUR_A: cur_a_nxt = pin_en;
      `CSM_SEL_CUR_B: cur_b_nxt = pin_en;
      `CSM_SEL_REF:   ref_nxt   = pin_en;
      default:        res_nxt   = 1'b1;   // reserved codes route nothing
    endcase
  end

  // ==========================================================
  // registered controls
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      route_cur_a        <= 1'b0;
      route_cur_b        <= 1'b0;
      route_ref          <= 1'b0;
      drive_oe           <= 1'b0;
      output_gain_select <= 2'h0;
      bias_remove        <= 1'b0;
      sel_reserved       <= 1'b0;
    end
    else
    begin
      route_cur_a        <= cur_a_nxt;
      route_cur_b        <= cur_b_nxt;
      route_ref          <= ref_nxt;
      drive_oe           <= pin_en;
      output_gain_select <= gain_code;
      bias_remove        <= gain_code[1];
      sel_reserved       <= res_nxt;
    end
  end

endmodule // csm_pin_slice

// file: hdl/csm_out_mux.v
// current sense output mux: registers, pin control, channel four comparator
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/100ps
`include "csm_consts.vh"

module csm_out_mux
#(
  parameter LVL_W = 8
)
(
  // clock and reset
  input  wire             clk,
  input  wire             reset_n,
  // wishbone slave
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [11:0]      wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output reg  [31:0]      wb_dat_o,
  output reg              wb_ack_o,
  // microcore config port
  input  wire             mc_wr_en,
  input  wire             mc_pin_sel,
  input  wire [15:0]      mc_wdata,
  output wire [15:0]      mc_out_one_cfg,
  output wire [15:0]      mc_out_two_cfg,
  // channel four comparator levels
  input  wire [LVL_W-1:0] chan_four_amp_level,
  input  wire [LVL_W-1:0] chan_four_dac_level,
  input  wire             chan_four_high_cmp,
  input  wire             chan_four_low_cmp,
  // channel four feedback to microcores
  output wire             chan_four_high_feedback,
  output wire             chan_four_low_feedback,
  output wire             chan_four_negative_feedback,
  // pin one analogue switch controls
  output wire             pin_one_route_cur1,
  output wire             pin_one_route_cur3,
  output wire             pin_one_route_ref,
  output wire             sense_out_pin_one_oe,
  output wire [1:0]       pin_one_gain_select,
  output wire             pin_one_bias_remove,
  // pin two analogue switch controls
  output wire             pin_two_route_cur2,
  output wire             pin_two_route_cur4,
  output wire             pin_two_route_ref,
  output wire             sense_out_pin_two_oe,
  output wire [1:0]       pin_two_gain_select,
  output wire             pin_two_bias_remove
);

  // ==========================================================
  // functions
  function [15:0] cfg_merge;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0]  lanes;
    reg   [15:0] tmp;
    begin
      tmp = old_val;
      if (lanes[0])
      begin
        tmp[7:0] = new_val[7:0];
      end
      if (lanes[1])
      begin
        tmp[15:8] = new_val[15:8];
      end
      cfg_merge = tmp & `CSM_CFG_MASK;
    end
  endfunction

  function is_reserved;
    input [2:0] code;
    begin
      is_reserved = (code != `CSM_SEL_CUR_A) &&
                    (code != `CSM_SEL_CUR_B) &&
                    (code != `CSM_SEL_REF);
    end
  endfunction

  function idx_hit;
    input [11:0] adr;
    input [9:0]  idx;
    begin
      idx_hit = (adr[1:0] == 2'h0) && (adr[11:2] == idx);
    end
  endfunction

  // ==========================================================
  // registers
  reg  [15:0] out_one_cfg_r;
  reg  [15:0] out_two_cfg_r;
  reg  [15:0] out_one_cfg_nxt;
  reg  [15:0] out_two_cfg_nxt;

  // ==========================================================
  // bus decode
  wire        bus_req;
  wire        bus_wr;
  wire        bus_rd;
  wire        hit_one;
  wire        hit_two;
  wire        hit_status;

  assign bus_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr     = bus_req & wb_we_i;
  assign bus_rd     = bus_req & ~wb_we_i;
  assign hit_one    = idx_hit(wb_adr_i, `CSM_IDX_OUT_ONE_CFG);
  assign hit_two    = idx_hit(wb_adr_i, `CSM_IDX_OUT_TWO_CFG);
  assign hit_status = idx_hit(wb_adr_i, `CSM_IDX_STATUS);

  // ==========================================================
  // field views
  wire [2:0]  pin_one_source_field;
  wire [2:0]  pin_two_source_field;
  wire        pin_one_enable;
  wire        pin_two_enable;
  wire [1:0]  pin_one_gain_code;
  wire [1:0]  pin_two_gain_code;

  assign pin_one_source_field = out_one_cfg_r[`CSM_SRC_MSB:`CSM_SRC_LSB];
  assign pin_two_source_field = out_two_cfg_r[`CSM_SRC_MSB:`CSM_SRC_LSB];
  assign pin_one_enable       = out_one_cfg_r[`CSM_EN_BIT];
  assign pin_two_enable       = out_two_cfg_r[`CSM_EN_BIT];
  assign pin_one_gain_code    = out_one_cfg_r[`CSM_GAIN_MSB:`CSM_GAIN_LSB];
  assign pin_two_gain_code    = out_two_cfg_r[`CSM_GAIN_MSB:`CSM_GAIN_LSB];

  // ==========================================================
  // write strobes, microcore wins a same-cycle clash
  wire        bus_wr_one;
  wire        bus_wr_two;
  wire        mc_wr_one;
  wire        mc_wr_two;
  wire [15:0] bus_one_val;
  wire [15:0] bus_two_val;
  wire [15:0] mc_one_val;
  wire [15:0] mc_two_val;

  assign bus_wr_one  = bus_wr & hit_one;
  assign bus_wr_two  = bus_wr & hit_two;
  assign mc_wr_one   = mc_wr_en & ~mc_pin_sel;
  assign mc_wr_two   = mc_wr_en & mc_pin_sel;
  assign bus_one_val = cfg_merge(out_one_cfg_r, wb_dat_i[15:0], wb_sel_i[1:0]);
  assign bus_two_val = cfg_merge(out_two_cfg_r, wb_dat_i[15:0], wb_sel_i[1:0]);
  assign mc_one_val  = cfg_merge(out_one_cfg_r, mc_wdata, 2'h3);
  assign mc_two_val  = cfg_merge(out_two_cfg_r, mc_wdata, 2'h3);

  // ==========================================================
  // config next values
  always @*
  begin
    out_one_cfg_nxt = out_one_cfg_r;
    if (mc_wr_one)
    begin
      out_one_cfg_nxt = mc_one_val;
    end
    else if (bus_wr_one)
    begin
      out_one_cfg_nxt = bus_one_val;
    end
  end

  always @*
  begin
    out_two_cfg_nxt = out_two_cfg_r;
    if (mc_wr_two)
    begin
      out_two_cfg_nxt = mc_two_val;
    end
    else if (bus_wr_two)
    begin
      out_two_cfg_nxt = bus_two_val;
    end
  end

  // ==========================================================
  // config registers
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_one_cfg_r <= `CSM_CFG_RESET;
    end
    else
    begin
      out_one_cfg_r <= out_one_cfg_nxt;
    end
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_two_cfg_r <= `CSM_CFG_RESET;
    end
    else
    begin
      out_two_cfg_r <= out_two_cfg_nxt;
    end
  end

  assign mc_out_one_cfg = out_one_cfg_r;
  assign mc_out_two_cfg = out_two_cfg_r;

  // ==========================================================
  // channel four comparator
  // straight compare, no hysteresis and no trim input on this path
  wire        neg_cmp_gt;

  assign neg_cmp_gt = (chan_four_amp_level > chan_four_dac_level);
  assign chan_four_negative_feedback = neg_cmp_gt;
  assign chan_four_high_feedback = chan_four_high_cmp;
  assign chan_four_low_feedback  = chan_four_low_cmp;

  // ==========================================================
  // pin slices
  wire        pin_one_reserved;
  wire        pin_two_reserved;

  csm_pin_slice u_pin_one
  (
    .clk                (clk),
    .reset_n            (reset_n),
    .src_sel            (pin_one_source_field),
    .pin_en             (pin_one_enable),
    .gain_code          (pin_one_gain_code),
    .route_cur_a        (pin_one_route_cur1),
    .route_cur_b        (pin_one_route_cur3),
    .route_ref          (pin_one_route_ref),
    .drive_oe           (sense_out_pin_one_oe),
    .output_gain_select (pin_one_gain_select),
    .bias_remove        (pin_one_bias_remove),
    .sel_reserved       (pin_one_reserved)
  );

  csm_pin_slice u_pin_two
  (
    .clk                (clk),
    .reset_n            (reset_n),
    .src_sel            (pin_two_source_field),
    .pin_en             (pin_two_enable),
    .gain_code          (pin_two_gain_code),
    .route_cur_a        (pin_two_route_cur2),
    .route_cur_b        (pin_two_route_cur4),
    .route_ref          (pin_two_route_ref),
    .drive_oe           (sense_out_pin_two_oe),
    .output_gain_select (pin_two_gain_select),
    .bias_remove        (pin_two_bias_remove),
    .sel_reserved       (pin_two_reserved)
  );

  // ==========================================================
  // status word
  wire        res_one_flag;
  wire        res_two_flag;
  reg  [15:0] status_word;

  assign res_one_flag = pin_one_reserved | is_reserved(pin_one_source_field);
  assign res_two_flag = pin_two_reserved | is_reserved(pin_two_source_field);

  always @*
  begin
    status_word                      = 16'h0000;
    status_word[`CSM_ST_HIGH_BIT]    = chan_four_high_feedback;
    status_word[`CSM_ST_LOW_BIT]     = chan_four_low_feedback;
    status_word[`CSM_ST_NEG_BIT]     = chan_four_negative_feedback;
    status_word[`CSM_ST_RES_ONE_BIT] = res_one_flag;
    status_word[`CSM_ST_RES_TWO_BIT] = res_two_flag;
  end

  // ==========================================================
  // read mux
  reg  [31:0] rd_nxt;

  always @*
  begin
    rd_nxt = 32'h00000000;
    case ({hit_status, hit_two, hit_one})
      3'h1:
      begin
        rd_nxt[15:0] = out_one_cfg_r;
      end
      3'h2:
      begin
        rd_nxt[15:0] = out_two_cfg_r;
      end
      3'h4:
      begin
        rd_nxt[15:0] = status_word;
      end
      default:
      begin
        rd_nxt = 32'h00000000;
      end
    endcase
  end

  // ==========================================================
  // wishbone answer: one wait state, ack for one cycle
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= bus_req;
    end
  end

  // read data register, holds until the next read
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wb_dat_o <= 32'h00000000;
    end
    else if (bus_rd)
    begin
      wb_dat_o <= rd_nxt;
    end
  end

endmodule // csm_out_mux

// file: test/csm_out_mux_chk.sv
// port checker for the current sense output mux
`timescale 1ns/100ps
module csm_out_mux_chk #(parameter LVL_W = 8) (
  // clock, reset and bus
  input wire             clk, reset_n, wb_cyc_i, wb_stb_i, wb_ack_o,
  // microcore port and comparator
  input wire             mc_wr_en, mc_pin_sel,
  input wire [15:0]      mc_wdata, mc_out_one_cfg, mc_out_two_cfg,
  input wire [LVL_W-1:0] chan_four_amp_level, chan_four_dac_level,
  input wire             chan_four_high_cmp, chan_four_low_cmp,
  input wire             chan_four_high_feedback, chan_four_low_feedback,
  input wire             chan_four_negative_feedback,
  // pin controls
  input wire             pin_one_route_cur1, pin_one_route_cur3, pin_one_route_ref,
  input wire             pin_two_route_cur2, pin_two_route_cur4, pin_two_route_ref,
  input wire             sense_out_pin_one_oe, sense_out_pin_two_oe,
  input wire             pin_one_bias_remove, pin_two_bias_remove,
  input wire [1:0]       pin_one_gain_select, pin_two_gain_select
);
  // ====
  // helpers
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire [2:0] s1 = mc_out_one_cfg[2:0];
  wire [2:0] s2 = mc_out_two_cfg[2:0];
  wire       gt = chan_four_amp_level > chan_four_dac_level;
  sequence take_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence pulse_s; wb_ack_o ##1 !wb_ack_o; endsequence
  // ====
  // assertions
  bus_ack_a: assert property (take_s |=> pulse_s)
    else $error("bus ack not a single pulse");
  mc_write_a: assert property (mc_wr_en && !mc_pin_sel |=>
    mc_out_one_cfg == ($past(mc_wdata) & 16'h003F)) else $error("microcore write lost");
  neg_cmp_a: assert property (chan_four_negative_feedback == gt)
    else $error("negative compare wrong");
  no_hyst_a: assert property ($fell(gt) |-> !chan_four_negative_feedback)
    else $error("negative compare lags");
  fb_pass_a: assert property ({chan_four_high_feedback, chan_four_low_feedback} ==
    {chan_four_high_cmp, chan_four_low_cmp}) else $error("feedback not direct");
  gain_fol_a: assert property ({pin_one_gain_select, pin_two_gain_select} ==
    {$past(mc_out_one_cfg[5:4]), $past(mc_out_two_cfg[5:4])}) else $error("gain wrong");
  bias_ctl_a: assert property ({pin_one_bias_remove, pin_two_bias_remove} ==
    {pin_one_gain_select[1], pin_two_gain_select[1]}) else $error("bias control wrong");
  route_one_a: assert property ($past(mc_out_one_cfg[3]) |->
    {pin_one_route_cur1, pin_one_route_cur3, pin_one_route_ref} ==
    {$past(s1 == 3'h0), $past(s1 == 3'h1), $past(s1 == 3'h5)}) else $error("pin one route");
  route_two_a: assert property ($past(mc_out_two_cfg[3]) |->
    {pin_two_route_cur2, pin_two_route_cur4, pin_two_route_ref} ==
    {$past(s2 == 3'h0), $past(s2 == 3'h1), $past(s2 == 3'h5)}) else $error("pin two route");
  pin_oe_a: assert property ({sense_out_pin_one_oe, sense_out_pin_two_oe} ==
    {$past(mc_out_one_cfg[3]), $past(mc_out_two_cfg[3])}) else $error("enable wrong");
endmodule // csm_out_mux_chk

bind csm_out_mux csm_out_mux_chk #(.LVL_W(LVL_W)) chk_u (.*);

// file: test/csm_mc_model.sv
// microcore and channel four comparator model
`timescale 1ns/100ps
module csm_mc_model #(parameter LVL_W = 8) (
  // clock
  input  wire              clk,
  // microcore config port
  output logic             mc_wr_en   = 1'h0,
  output logic             mc_pin_sel = 1'h0,
  output logic [15:0]      mc_wdata   = 16'h0000,
  // comparator levels
  output logic [LVL_W-1:0] amp = '0,
  output logic [LVL_W-1:0] dac = '0,
  output logic             hi  = 1'h0,
  output logic             lo  = 1'h0
);
  // ====
  // config write, reserved codes skipped only when the enable bit d[3] is set
  task cfg(input logic p, input logic [15:0] d);
    if (d[3] && d[2:0] != 3'h0 && d[2:0] != 3'h1 && d[2:0] != 3'h5)
      return;
    @(posedge clk);
    {mc_wr_en, mc_pin_sel, mc_wdata} <= {1'h1, p, d};
    @(posedge clk);
    {mc_wr_en, mc_pin_sel, mc_wdata} <= {1'h0, ~p, ~d};
  endtask
  // ====
  // analogue levels and comparator outputs
  task lvl(input logic [LVL_W-1:0] a, b, input logic h, l);
    @(posedge clk);
    {amp, dac, hi, lo} <= {a, b, h, l};
  endtask
endmodule // csm_mc_model

// file: test/tb.sv
// self-checking bench for the current sense output mux
`timescale 1ns/100ps
module tb;
  // ====
  // signals
  logic        clk = 1'h0, reset_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, rd;
  logic [13:0] r;
  logic [6:0]  po;
  wire  [31:0] wdo;
  wire  [15:0] mwd, c1, c2;
  wire  [7:0]  amp, dac;
  wire  [6:0]  p1, p2;
  wire         ack, mwe, mps, hc, lc, hf, lf, nf;
  int          n_errors = 0, n_compared = 0, cyc_n = 0;
  // rows: pin, config, expected {routes, oe, gain, bias}
  logic [13:0] rows [11] = '{14'h0448, 14'h0CAA, 14'h169D, 14'h1D0F, 14'h0000,
    14'h1A87, 14'h2448, 14'h3CAF, 14'h2E9A, 14'h378D, 14'h2080};
  // levels: amp, dac, high, low
  logic [17:0] lv [6] = '{18'h0403E, 18'h03C3D, 18'h0383F, 18'h3FC00, 18'h003FE, 18'h04040};
  always #20 clk = ~clk;
  // ====
  // instances
  csm_out_mux dut_u (.clk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack),
    .mc_wr_en(mwe), .mc_pin_sel(mps), .mc_wdata(mwd), .mc_out_one_cfg(c1),
    .mc_out_two_cfg(c2), .chan_four_amp_level(amp), .chan_four_dac_level(dac),
    .chan_four_high_cmp(hc), .chan_four_low_cmp(lc), .chan_four_high_feedback(hf),
    .chan_four_low_feedback(lf), .chan_four_negative_feedback(nf),
    .pin_one_route_cur1(p1[6]), .pin_one_route_cur3(p1[5]), .pin_one_route_ref(p1[4]),
    .sense_out_pin_one_oe(p1[3]), .pin_one_gain_select(p1[2:1]),
    .pin_one_bias_remove(p1[0]), .pin_two_route_cur2(p2[6]), .pin_two_route_cur4(p2[5]),
    .pin_two_route_ref(p2[4]), .sense_out_pin_two_oe(p2[3]),
    .pin_two_gain_select(p2[2:1]), .pin_two_bias_remove(p2[0]));
  csm_mc_model mc_u (.clk, .mc_wr_en(mwe), .mc_pin_sel(mps), .mc_wdata(mwd), .amp, .dac,
    .hi(hc), .lo(lc));
  // ====
  // tasks
  task chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e)
      begin
        n_errors++;
        $display("Error %0t: got %h want %h", $time, g, e);
      end
  endtask
  task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, 4'h3};
    do
      begin
        @(posedge clk);
        k++;
      end
    while (ack !== 1'h1);
    rd = wdo;
    {cyc, stb, we} <= 3'h0;
    @(posedge clk);
    chk(k, 2);
  endtask
  task final_report;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000)
    begin
      n_errors++;
      final_report;
    end
  end
  // ====
  // sequence
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    chk({c1, c2}, 32'h0);
    chk({18'h0, p1, p2}, 32'h0);
    foreach (rows[i])
    begin
      r = rows[i];
      po = r[13] ? p1 : p2;
      wb(1'h1, r[13] ? 12'h6AC : 12'h6A8, {26'h0, r[12:7]});
      chk((r[13] ? p2 : p1) & (r[10] ? 7'h7F : 7'h0F), r[6:0]);
      chk(r[13] ? p1 : p2, po);
      wb(1'h0, r[13] ? 12'h6AC : 12'h6A8, 32'h0);
      chk(rd, {26'h0, r[12:7]});
    end
    $display("test rows done");
    wb(1'h1, 12'h6B4, 32'hFFFF);
    wb(1'h0, 12'h6B4, 32'h0);
    chk(rd, 0);
    wb(1'h0, 12'h6A9, 32'h0);
    chk(rd, 0);
    $display("test unmapped done");
    mc_u.cfg(1'h1, 16'hFF3D);
    repeat (2) @(posedge clk);
    chk({c2, p2}, {16'h003D, 7'h1F});
    mc_u.cfg(1'h0, 16'hC0C8);
    repeat (2) @(posedge clk);
    chk({c1, 9'h0, p1}, {16'h0008, 9'h0, 7'h48});
    $display("test microcore done");
    foreach (lv[i])
    begin
      mc_u.lvl(lv[i][17:10], lv[i][9:2], lv[i][1], lv[i][0]);
      @(posedge clk);
      chk({hf, lf, nf}, {lv[i][1:0], lv[i][17:10] > lv[i][9:2]});
      wb(1'h0, 12'h6B0, 32'h0);
      chk(rd[2:0], {lv[i][17:10] > lv[i][9:2], lv[i][0], lv[i][1]});
    end
    $display("test comparator done");
    reset_n <= 1'h0;
    repeat (2) @(posedge clk);
    chk({c1, c2}, 32'h0);
    chk({18'h0, p1, p2}, 32'h0);
    reset_n <= 1'h1;
    @(posedge clk);
    $display("test reset done");
    final_report;
  end
endmodule // tb
